//--- rtl/phyx_ext_regs.sv
/*
 * extended control and status register slice of a 10/100 transceiver, reached over mdc/mdio.
 * assumes datapath status inputs come from logic on core_clk_i; strap and mdio pins are asynchronous.
 * assumes srst_i is held for at least three edges so the strap reaches the capture flop.
 */
`timescale 1ns/10ps
module phyx_ext_regs
    import phyx_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic [2:0] phy_addr_strap_i,
    input wire logic lp_page_stb_i,
    input wire logic [3:0] lp_code_i,
    input wire logic speed_100_i,
    input wire logic link_up_i,
    input wire logic full_duplex_i,
    input wire logic an_progress_stb_i,
    input wire logic [2:0] an_progress_i,
    output logic override_wr_en_o,
    output logic cipher_test_o,
    output logic nrzi_sel_o,
    output logic tx_invalid_o,
    output logic cipher_dis_o
);

    logic [2:0] strap_s1_r, strap_s2_r, phy_addr_r, phy_addr_nxt;
    logic rd_stb, wr_stb;
    logic [4:0] reg_addr;
    logic [15:0] wdata, rdata;
    logic [3:0] lp_code_r, lp_code_nxt;
    logic ovr_r, ovr_nxt, ctest_r, ctest_nxt, nrzi_r, nrzi_nxt;
    logic txinv_r, txinv_nxt, cdis_r, cdis_nxt;
    logic speed_r, speed_nxt, duplex_r, duplex_nxt;
    logic [2:0] prog_r, prog_nxt;
    logic wr_ext;

    ////////////////////////////////////////////////////////////////////////////
    // serial engine
    phyx_mdio_slave u_mdio (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .mdc_i(mdc_i),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe_o(mdio_oe_o),
        .phy_addr_i({EC_PHYAD_UPPER, phy_addr_r}),
        .rd_stb_o(rd_stb),
        .wr_stb_o(wr_stb),
        .reg_addr_o(reg_addr),
        .wdata_o(wdata),
        .rdata_i(rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // strap capture: sampled while reset is held, so the address is stable once frames start
    always_comb begin
        phy_addr_nxt = srst_i ? strap_s2_r : phy_addr_r;
    end

    always_ff @(posedge core_clk_i) begin
        strap_s1_r <= phy_addr_strap_i;
        strap_s2_r <= strap_s1_r;
        phy_addr_r <= phy_addr_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register state
    assign wr_ext = wr_stb && (reg_addr == ADDR_EXT_CTRL);

    always_comb begin
        lp_code_nxt = lp_page_stb_i ? lp_code_i : lp_code_r;
        ovr_nxt = wr_ext && wdata[EC_OVERRIDE_BIT];
        ctest_nxt = wr_ext ? wdata[EC_CIPHER_TEST_BIT] : ctest_r;
        nrzi_nxt = wr_ext ? wdata[EC_NRZI_BIT] : nrzi_r;
        txinv_nxt = wr_ext ? wdata[EC_TX_INVALID_BIT] : txinv_r;
        cdis_nxt = wr_ext ? wdata[EC_CIPHER_DIS_BIT] : cdis_r;
        speed_nxt = speed_100_i;
        // half duplex is unsupported, so an operating link always shows full
        duplex_nxt = full_duplex_i | link_up_i;
        prog_nxt = an_progress_stb_i ? an_progress_i : prog_r;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            lp_code_r <= LP_CODE_RST;
            ovr_r <= EC_OVERRIDE_RST;
            ctest_r <= EC_CIPHER_TEST_RST;
            nrzi_r <= EC_NRZI_RST;
            txinv_r <= EC_TX_INVALID_RST;
            cdis_r <= EC_CIPHER_DIS_RST;
            speed_r <= 1'b0;
            duplex_r <= 1'b0;
            prog_r <= QP_PROG_RST;
        end else begin
            lp_code_r <= lp_code_nxt;
            ovr_r <= ovr_nxt;
            ctest_r <= ctest_nxt;
            nrzi_r <= nrzi_nxt;
            txinv_r <= txinv_nxt;
            cdis_r <= cdis_nxt;
            speed_r <= speed_nxt;
            duplex_r <= duplex_nxt;
            prog_r <= prog_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; bits outside this slice and unmapped addresses read zero
    always_comb begin
        rdata = 16'h0000;
        unique case (reg_addr)
            ADDR_LP_NEXT_PAGE: begin
                rdata[3:0] = lp_code_r;
            end
            ADDR_EXT_CTRL: begin
                rdata[EC_OVERRIDE_BIT] = ovr_r;
                rdata[EC_PHYAD_HI:EC_PHYAD_LO] = {EC_PHYAD_UPPER, phy_addr_r};
                rdata[EC_CIPHER_TEST_BIT] = ctest_r;
                rdata[EC_NRZI_BIT] = nrzi_r;
                rdata[EC_TX_INVALID_BIT] = txinv_r;
                rdata[EC_CIPHER_DIS_BIT] = cdis_r;
            end
            ADDR_QP_STATUS: begin
                rdata[QP_SPEED_BIT] = speed_r;
                rdata[QP_DUPLEX_BIT] = duplex_r;
                rdata[QP_PROG_HI:QP_PROG_LO] = prog_r;
            end
            default: begin
                rdata = 16'h0000;
            end
        endcase
    end

    assign override_wr_en_o = ovr_r;
    assign cipher_test_o = ctest_r;
    assign nrzi_sel_o = nrzi_r;
    assign tx_invalid_o = txinv_r;
    assign cipher_dis_o = cdis_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // reset edges stay out of the antecedents: a flop forced by reset ignores its inputs

    a_lp_code_follow: assert property (lp_page_stb_i |=> lp_code_r == $past(lp_code_i)
        ##0 (reg_addr != ADDR_LP_NEXT_PAGE || rdata == {12'h000, lp_code_r}))
        else $error("partner code not captured");
    a_reserved_zero: assert property ((reg_addr >= ADDR_RSV_LO && reg_addr <= ADDR_RSV_HI) |-> rdata == 16'h0000)
        else $error("reserved address reads nonzero");
    a_lp_code_hold: assert property (!lp_page_stb_i |=> $stable(lp_code_r))
        else $error("partner code changed without a page");
    a_lp_upper_zero: assert property ((reg_addr == ADDR_LP_NEXT_PAGE) |-> rdata[15:4] == 12'h000)
        else $error("partner register upper bits nonzero");
    a_unmapped_zero: assert property ((reg_addr < ADDR_LP_NEXT_PAGE || reg_addr > ADDR_QP_STATUS)
        |-> rdata == 16'h0000)
        else $error("unmapped address reads nonzero");

    ////////////////////////////////////////////////////////////////////////////
    // extended control
    a_override_pulse: assert property ((wr_ext && wdata[EC_OVERRIDE_BIT]) |=> override_wr_en_o ##1 !override_wr_en_o)
        else $error("override enable did not self clear");
    a_ctrl_write: assert property (wr_ext |=> nrzi_sel_o == $past(wdata[EC_NRZI_BIT])
        && cipher_dis_o == $past(wdata[EC_CIPHER_DIS_BIT]) && tx_invalid_o == $past(wdata[EC_TX_INVALID_BIT]))
        else $error("control write not stored");
    a_cipher_test: assert property (wr_ext |=> cipher_test_o == $past(wdata[EC_CIPHER_TEST_BIT]))
        else $error("cipher test select not stored");
    a_ctrl_hold: assert property (!wr_ext |=> $stable({cipher_test_o, nrzi_sel_o, tx_invalid_o, cipher_dis_o}))
        else $error("control changed without a write");
    a_ctrl_reset: assert property (disable iff (1'b0) srst_i |=> nrzi_sel_o && !cipher_dis_o
        && !cipher_test_o && !tx_invalid_o && !override_wr_en_o)
        else $error("control reset values wrong");
    a_addr_readback: assert property ((reg_addr == ADDR_EXT_CTRL) |-> rdata[EC_PHYAD_HI:EC_PHYAD_LO]
        == {2'h0, phy_addr_r} && rdata[14:11] == 4'h0)
        else $error("address readback wrong");
    a_override_idle: assert property (!(wr_ext && wdata[EC_OVERRIDE_BIT]) |=> !override_wr_en_o)
        else $error("override enable without a write");
    a_override_read: assert property ((reg_addr == ADDR_EXT_CTRL) |-> rdata[EC_OVERRIDE_BIT] == override_wr_en_o)
        else $error("override readback wrong");
    a_ext_rsv_zero: assert property ((reg_addr == ADDR_EXT_CTRL) |-> !rdata[4] && !rdata[1])
        else $error("control reserved bits nonzero");
    a_addr_stable: assert property (!srst_i |=> $stable(phy_addr_r))
        else $error("address moved outside reset");

    ////////////////////////////////////////////////////////////////////////////
    // quick poll status
    a_speed_flag: assert property ((reg_addr == ADDR_QP_STATUS) ##1 (reg_addr == ADDR_QP_STATUS)
        |-> rdata[QP_SPEED_BIT] == $past(speed_100_i))
        else $error("speed flag does not track rate");
    a_duplex_link: assert property (link_up_i && !srst_i |=> duplex_r)
        else $error("duplex not full while link up");
    a_prog_latch: assert property (!an_progress_stb_i |=> $stable(prog_r))
        else $error("progress code changed without update");
    a_prog_load: assert property (an_progress_stb_i |=> prog_r == $past(an_progress_i))
        else $error("progress code not loaded");
    a_duplex_follow: assert property (!link_up_i && !srst_i |=> duplex_r == $past(full_duplex_i))
        else $error("duplex does not follow the datapath");
    a_qp_low_zero: assert property ((reg_addr == ADDR_QP_STATUS) |-> rdata[10:0] == 11'h000)
        else $error("quick poll low bits nonzero");

    c_read_frame: cover property (rd_stb ##[1:400] mdio_oe_o);
    c_write_ext: cover property (wr_ext);
    c_override: cover property (override_wr_en_o ##1 !override_wr_en_o);
    c_reserved_read: cover property (rd_stb && reg_addr >= ADDR_RSV_LO && reg_addr <= ADDR_RSV_HI);
    c_prog_load: cover property (an_progress_stb_i);

endmodule : phyx_ext_regs

//--- rtl/phyx_pkg.sv
/*
 * constants for the extended control and status register slice:
 * register addresses, field positions, reset values and management frame layout.
 * assumes a 5-bit register address and 16-bit register data on the management bus.
 */
package phyx_pkg;

    localparam int unsigned REG_ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [4:0] ADDR_LP_NEXT_PAGE = 5'h08;
    localparam logic [4:0] ADDR_RSV_LO = 5'h09;
    localparam logic [4:0] ADDR_RSV_HI = 5'h0F;
    localparam logic [4:0] ADDR_EXT_CTRL = 5'h10;
    localparam logic [4:0] ADDR_QP_STATUS = 5'h11;

    ////////////////////////////////////////////////////////////////////////////
    // extended control fields
    localparam int unsigned EC_OVERRIDE_BIT = 15;
    localparam int unsigned EC_PHYAD_HI = 10;
    localparam int unsigned EC_PHYAD_LO = 6;
    localparam int unsigned EC_CIPHER_TEST_BIT = 5;
    localparam int unsigned EC_NRZI_BIT = 3;
    localparam int unsigned EC_TX_INVALID_BIT = 2;
    localparam int unsigned EC_CIPHER_DIS_BIT = 0;
    localparam logic EC_OVERRIDE_RST = 1'h0;
    localparam logic EC_CIPHER_TEST_RST = 1'h0;
    localparam logic EC_NRZI_RST = 1'h1;
    localparam logic EC_TX_INVALID_RST = 1'h0;
    localparam logic EC_CIPHER_DIS_RST = 1'h0;
    localparam logic [1:0] EC_PHYAD_UPPER = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // quick poll status and partner page fields
    localparam int unsigned QP_SPEED_BIT = 15;
    localparam int unsigned QP_DUPLEX_BIT = 14;
    localparam int unsigned QP_PROG_HI = 13;
    localparam int unsigned QP_PROG_LO = 11;
    localparam logic [2:0] QP_PROG_RST = 3'h0;
    localparam logic [3:0] LP_CODE_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // management frame layout
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0C;
    localparam logic [5:0] DATA_LAST = 6'h0F;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    typedef enum logic [1:0] {
        PHYX_IDLE = 2'b00,
        PHYX_HDR = 2'b01,
        PHYX_TA = 2'b10,
        PHYX_DATA = 2'b11
    } phyx_mdio_st_t;

endpackage : phyx_pkg

//--- rtl/phyx_mdio_slave.sv
/*
 * serial management frame engine: preamble, header decode, turnaround, data shift.
 * assumes mdc runs at most a tenth of core_clk_i; mdc and mdio are resynchronised here.
 */
`timescale 1ns/10ps
module phyx_mdio_slave
    import phyx_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic [4:0] phy_addr_i,
    output logic rd_stb_o,
    output logic wr_stb_o,
    output logic [4:0] reg_addr_o,
    output logic [15:0] wdata_o,
    input wire logic [15:0] rdata_i
);

    logic mdc_s1_r, mdc_s2_r, mdc_s3_r, mdio_s1_r, mdio_s2_r;
    phyx_mdio_st_t st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [4:0] addr_r, addr_nxt;
    logic rd_r, rd_nxt, o_r, o_nxt, oe_r, oe_nxt, rstb_r, rstb_nxt, wstb_r, wstb_nxt;
    logic rise, bit_in;
    logic [12:0] hdr;

    ////////////////////////////////////////////////////////////////////////////
    // two flops before anything looks at the pins
    always_ff @(posedge core_clk_i) begin
        mdc_s1_r <= mdc_i;
        mdc_s2_r <= mdc_s1_r;
        mdc_s3_r <= mdc_s2_r;
        mdio_s1_r <= mdio_i;
        mdio_s2_r <= mdio_s1_r;
    end

    assign rise = mdc_s2_r & ~mdc_s3_r;
    assign bit_in = mdio_s2_r;
    assign hdr = {sh_r[11:0], bit_in};

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        o_nxt = o_r;
        oe_nxt = oe_r;
        rstb_nxt = 1'b0;
        wstb_nxt = 1'b0;
        if (rstb_r) begin
            sh_nxt = rdata_i;
        end else if (rise) begin
            unique case (st_r)
                PHYX_IDLE: begin
                    if (bit_in) begin
                        cnt_nxt = (cnt_r == PREAMBLE_BITS) ? cnt_r : cnt_r + 6'h01;
                    end else begin
                        st_nxt = (cnt_r == PREAMBLE_BITS) ? PHYX_HDR : PHYX_IDLE;
                        cnt_nxt = 6'h00;
                    end
                end
                PHYX_HDR: begin
                    sh_nxt = {sh_r[14:0], bit_in};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == HDR_LAST) begin
                        cnt_nxt = 6'h00;
                        // frames for other addresses are ignored without driving the pin
                        if (hdr[12] && hdr[9:5] == phy_addr_i && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
                            st_nxt = PHYX_TA;
                            addr_nxt = hdr[4:0];
                            rd_nxt = (hdr[11:10] == OP_READ);
                            rstb_nxt = (hdr[11:10] == OP_READ);
                        end else begin
                            st_nxt = PHYX_IDLE;
                        end
                    end
                end
                PHYX_TA: begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == 6'h00) begin
                        oe_nxt = rd_r;
                        o_nxt = 1'b0;
                    end else begin
                        st_nxt = PHYX_DATA;
                        cnt_nxt = 6'h00;
                        if (rd_r) begin
                            o_nxt = sh_r[15];
                            sh_nxt = {sh_r[14:0], 1'b0};
                        end
                    end
                end
                PHYX_DATA: begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (rd_r) begin
                        o_nxt = sh_r[15];
                        sh_nxt = {sh_r[14:0], 1'b0};
                    end else begin
                        sh_nxt = {sh_r[14:0], bit_in};
                    end
                    if (cnt_r == DATA_LAST) begin
                        st_nxt = PHYX_IDLE;
                        cnt_nxt = 6'h00;
                        oe_nxt = 1'b0;
                        wstb_nxt = ~rd_r;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_r <= PHYX_IDLE;
            cnt_r <= 6'h00;
            sh_r <= 16'h0000;
            addr_r <= 5'h00;
            rd_r <= 1'b0;
            o_r <= 1'b0;
            oe_r <= 1'b0;
            rstb_r <= 1'b0;
            wstb_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            o_r <= o_nxt;
            oe_r <= oe_nxt;
            rstb_r <= rstb_nxt;
            wstb_r <= wstb_nxt;
        end
    end

    assign mdio_o = o_r;
    assign mdio_oe_o = oe_r;
    assign rd_stb_o = rstb_r;
    assign wr_stb_o = wstb_r;
    assign reg_addr_o = addr_r;
    assign wdata_o = sh_r;

endmodule : phyx_mdio_slave

//--- bench/phyx_sta_model.sv
/*
 * station management controller model: drives mdc and mdio frames, samples read data.
 * assumes the bench resolves the mdio wire with a pull-up and feeds it back on line_i.
 */
`timescale 1ns/10ps
module phyx_sta_model
    import phyx_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic line_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o,
    output logic rd_done_o,
    output logic [15:0] rd_data_o
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
        rd_done_o = 1'b0;
        rd_data_o = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one bit: 10 core cycles low, 10 high; mdc is core/20, inside the core/10 limit
    task automatic bit_cyc(input logic drv, input logic val, output logic smp);
        @(posedge core_clk_i);
        mdc_o <= 1'b0;
        mdio_oe_o <= drv;
        mdio_o <= val;
        repeat (10) @(posedge core_clk_i);
        mdc_o <= 1'b1;
        smp = line_i;
        repeat (9) @(posedge core_clk_i);
    endtask : bit_cyc
    // full 32-one preamble every frame; mdc stands low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, input logic rd);
        logic [63:0] w;
        logic s;
        logic [15:0] d;
        w = {32'hFFFFFFFF, 2'b01, op, phy, ra, 2'b10, wd};
        d = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            bit_cyc(!(rd && i < 18), w[i], s);
            if (i < 16) d[i] = s;
        end
        @(posedge core_clk_i);
        mdc_o <= 1'b0;
        mdio_oe_o <= 1'b0;
        rd_data_o <= d;
        rd_done_o <= rd;
        @(posedge core_clk_i);
        rd_done_o <= 1'b0;
        repeat (20) @(posedge core_clk_i);
    endtask : frame
endmodule : phyx_sta_model

//--- bench/phyx_ext_regs_bench.sv
/*
 * self-checking bench for the extended register slice, reads checked through a queue.
 * assumes the controller model in phyx_sta_model; mdio has a pull-up.
 */
`timescale 1ns/10ps
module phyx_ext_regs_bench
    import phyx_pkg::*;
;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic dut_o, dut_oe, pm_mdc, pm_o, pm_oe, line, rd_done;
    logic [15:0] rd_data;
    logic [2:0] strap = 3'h0;
    logic lp_stb = 1'b0;
    logic [3:0] lp_code = 4'h0;
    logic spd = 1'b0;
    logic link = 1'b0;
    logic fd = 1'b0;
    logic an_stb = 1'b0;
    logic [2:0] an_prog = 3'h0;
    logic ov, ct, nrzi, txi, cdis;
    logic [15:0] q[$];
    logic [15:0] v;
    logic [3:0] c;
    logic [2:0] p;
    logic f;
    int seed, err_count, num_checks, cyc, ov_cnt, n;
    always #20 core_clk = ~core_clk;
    // released wire floats up to the pull-up
    assign line = pm_oe ? pm_o : (dut_oe ? dut_o : 1'b1);
    phyx_ext_regs DUT (.core_clk_i(core_clk), .srst_i(srst), .mdc_i(pm_mdc), .mdio_i(line),
        .mdio_o(dut_o), .mdio_oe_o(dut_oe), .phy_addr_strap_i(strap), .lp_page_stb_i(lp_stb),
        .lp_code_i(lp_code), .speed_100_i(spd), .link_up_i(link), .full_duplex_i(fd),
        .an_progress_stb_i(an_stb), .an_progress_i(an_prog), .override_wr_en_o(ov),
        .cipher_test_o(ct), .nrzi_sel_o(nrzi), .tx_invalid_o(txi), .cipher_dis_o(cdis));
    phyx_sta_model pm (.core_clk_i(core_clk), .line_i(line), .mdc_o(pm_mdc), .mdio_o(pm_o),
        .mdio_oe_o(pm_oe), .rd_done_o(rd_done), .rd_data_o(rd_data));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        q.push_back(exp);
        pm.frame(OP_READ, {2'b00, strap}, ra, 16'h0000, 1'b1);
    endtask : rd
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        pm.frame(OP_WRITE, {2'b00, strap}, ra, wd, 1'b0);
    endtask : wr
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////
    // monitor: each finished read takes the oldest expectation
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (ov === 1'b1) ov_cnt <= ov_cnt + 1;
        if (rd_done === 1'b1) check(rd_data, q.pop_front());
        if (cyc == 80000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        seed = 32'h7843AD0B;
        strap <= 3'($random(seed));
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        check({11'h0, ov, ct, nrzi, txi, cdis}, 16'h0004);
        rd(ADDR_EXT_CTRL, {7'h00, strap, 6'h08});
        rd(ADDR_LP_NEXT_PAGE, 16'h0000);
        rd(ADDR_QP_STATUS, 16'h0000);
        // first pass sets override and random fields, second flips every field
        for (int j = 0; j < 2; j++) begin
            v = j ? (~v & 16'h7FFF) : (16'($random(seed)) | 16'h8000);
            n = ov_cnt;
            wr(ADDR_EXT_CTRL, v);
            check(16'(ov_cnt - n), j ? 16'h0000 : 16'h0001);
            check({12'h0, ct, nrzi, txi, cdis}, {12'h0, v[5], v[3], v[2], v[0]});
            rd(ADDR_EXT_CTRL, {7'h00, strap, v[5], 1'b0, v[3], v[2], 1'b0, v[0]});
        end
        // partner code loads only on its strobe; writes do not reach it
        c = 4'($random(seed));
        lp_code <= c;
        lp_stb <= 1'b1;
        @(posedge core_clk);
        lp_stb <= 1'b0;
        lp_code <= ~c;
        rd(ADDR_LP_NEXT_PAGE, {12'h0, c});
        wr(ADDR_LP_NEXT_PAGE, 16'hFFFF);
        rd(ADDR_LP_NEXT_PAGE, {12'h0, c});
        for (int a = 9; a <= 15; a++) begin
            wr(5'(a), 16'($random(seed)));
            rd(5'(a), 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            p = 3'($random(seed));
            f = 1'($random(seed));
            spd <= i[0];
            link <= i[1];
            fd <= f;
            an_prog <= p;
            an_stb <= 1'b1;
            @(posedge core_clk);
            an_stb <= 1'b0;
            an_prog <= ~p;
            rd(ADDR_QP_STATUS, {i[0], f | i[1], p, 11'h000});
        end
        // foreign address: nobody drives, pull-up reads all ones
        q.push_back(16'hFFFF);
        pm.frame(OP_READ, {2'b10, strap}, ADDR_EXT_CTRL, 16'h0000, 1'b1);
        // undefined opcodes are ignored: nothing is driven back and nothing is stored
        q.push_back(16'hFFFF);
        pm.frame(2'b11, {2'b00, strap}, ADDR_EXT_CTRL, 16'h0000, 1'b1);
        pm.frame(2'b00, {2'b00, strap}, ADDR_EXT_CTRL, 16'hFFFF, 1'b0);
        rd(ADDR_EXT_CTRL, {7'h00, strap, v[5], 1'b0, v[3], v[2], 1'b0, v[0]});
        // second reset with a new strap value
        strap <= 3'($random(seed));
        srst <= 1'b1;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        check({11'h0, ov, ct, nrzi, txi, cdis}, 16'h0004);
        rd(ADDR_EXT_CTRL, {7'h00, strap, 6'h08});
        rd(ADDR_LP_NEXT_PAGE, 16'h0000);
        rd(ADDR_QP_STATUS, 16'hC000);
        repeat (5) @(posedge core_clk);
        check(16'(q.size()), 16'h0000);
        stop_test();
    end
endmodule : phyx_ext_regs_bench
